// >>> src/aics_pkg.sv
// Package of constants for the amplifier input channel selector
package aics_pkg;
  // Bus byte addresses are four times the register index
  localparam logic [7:0] IDX_AMP_MODE = 8'h90;
  localparam logic [7:0] IDX_INPUT_SELECT = 8'h91;
  localparam logic [9:0] ADDR_AMP_MODE = {IDX_AMP_MODE, 2'h0};
  localparam logic [9:0] ADDR_INPUT_SELECT = {IDX_INPUT_SELECT, 2'h0};
  localparam int ADDR_W = 10;
  localparam int SEL_W = 3;
  localparam int GAIN_W = 3;
  // Input select field codes
  localparam logic [2:0] SEL_DIFF = 3'h0;
  localparam logic [2:0] SEL_POS_CM = 3'h1;
  localparam logic [2:0] SEL_NEG_CM = 3'h2;
  localparam logic [2:0] SEL_SHORT = 3'h3;
  localparam logic [2:0] SEL_RSV4 = 3'h4;
  localparam logic [2:0] SEL_TEMP = 3'h5;
  localparam logic [2:0] SEL_VDET = 3'h6;
  localparam logic [2:0] SEL_RSV7 = 3'h7;
  localparam logic [2:0] SEL_RESET = 3'h0;
  // Gain select field codes
  localparam logic [2:0] GAIN_16 = 3'h0;
  localparam logic [2:0] GAIN_32 = 3'h1;
  localparam logic [2:0] GAIN_64 = 3'h2;
  localparam logic [2:0] GAIN_128 = 3'h3;
  localparam logic [2:0] GAIN_UNITY = 3'h7;
  // Mode register layout and reset value
  localparam int MODE_ENABLE_BIT = 0;
  localparam int MODE_GAIN_LSB = 1;
  localparam int MODE_GAIN_MSB = 3;
  localparam logic [7:0] MODE_RESET = 8'hbe;
  // Multiplexer switch vector: positive side and negative side sources
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_POS_IN = 3'h1;
  localparam logic [2:0] SRC_NEG_IN = 3'h2;
  localparam logic [2:0] SRC_CM_REF = 3'h3;
  localparam logic [2:0] SRC_TEMP = 3'h4;
  localparam logic [2:0] SRC_FIXED = 3'h5;
  localparam logic [2:0] SRC_TAP_3 = 3'h6;
  localparam logic [2:0] SRC_TAP_2 = 3'h7;
  // Gain multipliers as log2 shift
  localparam logic [2:0] SHIFT_UNITY = 3'h0;
  localparam logic [2:0] SHIFT_16 = 3'h4;
  localparam logic [2:0] SHIFT_32 = 3'h5;
  localparam logic [2:0] SHIFT_64 = 3'h6;
  localparam logic [2:0] SHIFT_128 = 3'h7;
endpackage

// >>> src/aics_route.sv
// Combinational map from select and gain codes to mux switches and gain shift
`timescale 1ns/1ns
`default_nettype none
module aics_route
(
  input wire logic [2:0] i_select,
  input wire logic [2:0] i_gain,
  output logic [2:0] o_pos_src,
  output logic [2:0] o_neg_src,
  output logic [2:0] o_gain_shift,
  output logic o_gain_valid,
  output logic o_select_valid
);
  always_comb
  begin
    o_pos_src = aics_pkg::SRC_NONE;
    o_neg_src = aics_pkg::SRC_NONE;
    o_select_valid = 1'b1;
    case (i_select)
      aics_pkg::SEL_DIFF:
      begin
        o_pos_src = aics_pkg::SRC_POS_IN;
        o_neg_src = aics_pkg::SRC_NEG_IN;
      end
      aics_pkg::SEL_POS_CM:
      begin
        o_pos_src = aics_pkg::SRC_POS_IN;
        o_neg_src = aics_pkg::SRC_CM_REF;
      end
      aics_pkg::SEL_NEG_CM:
      begin
        o_pos_src = aics_pkg::SRC_NEG_IN;
        o_neg_src = aics_pkg::SRC_CM_REF;
      end
      aics_pkg::SEL_SHORT:
      begin
        o_pos_src = aics_pkg::SRC_CM_REF;
        o_neg_src = aics_pkg::SRC_CM_REF;
      end
      aics_pkg::SEL_TEMP:
      begin
        o_pos_src = aics_pkg::SRC_TEMP;
        o_neg_src = aics_pkg::SRC_FIXED;
      end
      aics_pkg::SEL_VDET:
      begin
        o_pos_src = aics_pkg::SRC_TAP_3;
        o_neg_src = aics_pkg::SRC_TAP_2;
      end
      default:
      begin
        // Reserved codes leave both switches open
        o_select_valid = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    o_gain_shift = aics_pkg::SHIFT_UNITY;
    o_gain_valid = 1'b1;
    if (i_select == aics_pkg::SEL_TEMP)
    begin
      // Sensor path is fixed at unity whatever the field holds
      o_gain_shift = aics_pkg::SHIFT_UNITY;
      o_gain_valid = (i_gain == aics_pkg::GAIN_UNITY);
    end
    else
    begin
      case (i_gain)
        aics_pkg::GAIN_16: o_gain_shift = aics_pkg::SHIFT_16;
        aics_pkg::GAIN_32: o_gain_shift = aics_pkg::SHIFT_32;
        aics_pkg::GAIN_64: o_gain_shift = aics_pkg::SHIFT_64;
        aics_pkg::GAIN_128: o_gain_shift = aics_pkg::SHIFT_128;
        aics_pkg::GAIN_UNITY: o_gain_shift = aics_pkg::SHIFT_UNITY;
        default: o_gain_valid = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> src/aics_top.sv
// Amplifier input channel selector: register slave and mux control outputs
// Behaviour
// - 3-bit read/write select field, bits 2:0 of register 0x91, reset to zero
// - Code 000 routes positive and negative inputs as a differential pair
// - Code 001 routes positive input against common-mode reference
// - Code 010 routes negative input against common-mode reference
// - Code 011 ties both amplifier inputs to common-mode reference for offset test
// - Code 101 feeds temperature sensor against fixed level at unity gain
// - Code 110 presents 3/16 versus 2/16 supply tap to the amplifier
// - Gain field: 111 unity, 000..011 give 16,32,64,128, rest reserved
// - Enable bit turns amplifier on when one, off when zero
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module aics_top
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [9:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_amp_enable,
  output logic [2:0] o_pos_src,
  output logic [2:0] o_neg_src,
  output logic [2:0] o_gain_shift,
  output logic o_gain_valid,
  output logic o_select_valid
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer on the second edge of a request
  logic ack;
  logic next_ack;
  logic [2:0] input_select_field;
  logic [2:0] next_input_select_field;
  logic [7:0] amp_mode_register;
  logic [7:0] next_amp_mode_register;
  logic [31:0] readdata;
  logic [31:0] next_readdata;
  logic req;
  logic take;
  logic [2:0] gain_field;

  assign req = i_read | i_write;
  assign take = req & ack;
  assign o_waitrequest = req & ~ack;

  always_comb
  begin
    next_ack = req & ~ack;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb
  begin
    next_input_select_field = input_select_field;
    next_amp_mode_register = amp_mode_register;
    if (take && i_write && i_byteenable[0])
    begin
      if (i_address == aics_pkg::ADDR_INPUT_SELECT)
      begin
        // Upper bits are not stored
        next_input_select_field = i_writedata[2:0];
      end
      if (i_address == aics_pkg::ADDR_AMP_MODE)
      begin
        next_amp_mode_register = i_writedata[7:0];
      end
    end
  end

  always_comb
  begin
    next_readdata = readdata;
    if (req && !ack && i_read)
    begin
      // Unmapped addresses read as zero
      next_readdata = 32'h0;
      if (i_address == aics_pkg::ADDR_INPUT_SELECT)
      begin
        next_readdata = {29'h0, input_select_field};
      end
      if (i_address == aics_pkg::ADDR_AMP_MODE)
      begin
        next_readdata = {24'h0, amp_mode_register};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers, one process per group
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= next_ack;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      input_select_field <= aics_pkg::SEL_RESET;
      amp_mode_register <= aics_pkg::MODE_RESET;
    end
    else
    begin
      input_select_field <= next_input_select_field;
      amp_mode_register <= next_amp_mode_register;
    end
  end

  // Read data captured in the wait cycle so it stands when waitrequest drops
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      readdata <= 32'h0;
    end
    else
    begin
      readdata <= next_readdata;
    end
  end

  assign o_readdata = readdata;

  ////////////////////////////////////////////////////////////////////////////
  // Mux and gain control
  // Enable is not gated by select changes so a channel swap never drops power
  assign o_amp_enable = amp_mode_register[aics_pkg::MODE_ENABLE_BIT];
  assign gain_field = amp_mode_register[aics_pkg::MODE_GAIN_MSB:aics_pkg::MODE_GAIN_LSB];

  aics_route u_route
  (
    .i_select(input_select_field),
    .i_gain(amp_mode_register[aics_pkg::MODE_GAIN_MSB:aics_pkg::MODE_GAIN_LSB]),
    .o_pos_src(o_pos_src),
    .o_neg_src(o_neg_src),
    .o_gain_shift(o_gain_shift),
    .o_gain_valid(o_gain_valid),
    .o_select_valid(o_select_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_select_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (take && i_write && i_byteenable[0] && i_address == aics_pkg::ADDR_INPUT_SELECT)
    |=> input_select_field == $past(i_writedata[2:0]))
    else $error("select field not written");
  a_select_readback: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (take && i_read && i_address == aics_pkg::ADDR_INPUT_SELECT)
    |-> o_readdata == {29'h0, input_select_field})
    else $error("select readback wrong");
  a_upper_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (take && i_read && i_address == aics_pkg::ADDR_INPUT_SELECT)
    |-> (o_readdata >> aics_pkg::SEL_W) == 32'h0)
    else $error("unused select bits not zero");
  a_lane_ignored: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (take && i_write && !i_byteenable[0])
    |=> $stable(input_select_field) && $stable(amp_mode_register))
    else $error("write without lane zero stored");
  a_diff_route: assert property (@(posedge i_clock) disable iff (!i_rstn)
    input_select_field == aics_pkg::SEL_DIFF
    |-> o_pos_src == aics_pkg::SRC_POS_IN && o_neg_src == aics_pkg::SRC_NEG_IN)
    else $error("differential route wrong");
  a_pos_route: assert property (@(posedge i_clock) disable iff (!i_rstn)
    input_select_field == aics_pkg::SEL_POS_CM
    |-> o_pos_src == aics_pkg::SRC_POS_IN && o_neg_src == aics_pkg::SRC_CM_REF)
    else $error("positive single route wrong");
  a_neg_route: assert property (@(posedge i_clock) disable iff (!i_rstn)
    input_select_field == aics_pkg::SEL_NEG_CM
    |-> o_pos_src == aics_pkg::SRC_NEG_IN && o_neg_src == aics_pkg::SRC_CM_REF)
    else $error("negative single route wrong");
  a_short_route: assert property (@(posedge i_clock) disable iff (!i_rstn)
    input_select_field == aics_pkg::SEL_SHORT
    |-> o_pos_src == aics_pkg::SRC_CM_REF && o_neg_src == aics_pkg::SRC_CM_REF)
    else $error("short route wrong");
  a_temp_unity: assert property (@(posedge i_clock) disable iff (!i_rstn)
    input_select_field == aics_pkg::SEL_TEMP
    |-> o_pos_src == aics_pkg::SRC_TEMP && o_neg_src == aics_pkg::SRC_FIXED
      && o_gain_shift == aics_pkg::SHIFT_UNITY)
    else $error("temperature path wrong");
  a_temp_gain_flag: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (input_select_field == aics_pkg::SEL_TEMP && gain_field != aics_pkg::GAIN_UNITY)
    |-> !o_gain_valid)
    else $error("sensor gain not flagged");
  a_vdet_route: assert property (@(posedge i_clock) disable iff (!i_rstn)
    input_select_field == aics_pkg::SEL_VDET
    |-> o_pos_src == aics_pkg::SRC_TAP_3 && o_neg_src == aics_pkg::SRC_TAP_2)
    else $error("detection tap wrong");
  a_gain_128: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (input_select_field != aics_pkg::SEL_TEMP && gain_field == aics_pkg::GAIN_128)
    |-> o_gain_shift == aics_pkg::SHIFT_128 && o_gain_valid)
    else $error("gain decode wrong");
  a_gain_reserved: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (gain_field > aics_pkg::GAIN_128 && gain_field != aics_pkg::GAIN_UNITY)
    |-> !o_gain_valid)
    else $error("reserved gain accepted");
  a_enable_follows: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (take && i_write && i_byteenable[0] && i_address == aics_pkg::ADDR_AMP_MODE)
    |=> o_amp_enable == $past(i_writedata[0]))
    else $error("enable bit not applied");
  a_enable_kept: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (take && i_write && i_address == aics_pkg::ADDR_INPUT_SELECT)
    |=> $stable(o_amp_enable))
    else $error("select write moved enable");
  a_reserved_open: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (input_select_field == aics_pkg::SEL_RSV4 || input_select_field == aics_pkg::SEL_RSV7)
    |-> !o_select_valid && o_pos_src == aics_pkg::SRC_NONE && o_neg_src == aics_pkg::SRC_NONE)
    else $error("reserved code routed");
  a_wait_one: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (req && !ack) |=> (!req || !o_waitrequest))
    else $error("waitrequest held too long");
endmodule
`default_nettype wire

// >>> test/aics_amp_model.sv
// Behavioural model of the analog input mux and gain amplifier
`timescale 1ns/1ns
`default_nettype none
module aics_amp_model
#(
  parameter int POS_MV = 900,
  parameter int NEG_MV = 700,
  parameter int CM_MV = 400,
  parameter int TS_MV = 800,
  parameter int FIX_MV = 300,
  parameter int VDD_MV = 1600
)
(
  input wire logic i_enable,
  input wire logic [2:0] i_pos_src,
  input wire logic [2:0] i_neg_src,
  input wire logic [2:0] i_gain_shift,
  output logic [31:0] o_level
);
  ////////////////////////////////////////
  function automatic int volt(input logic [2:0] s);
    case (s)
      aics_pkg::SRC_POS_IN: volt = POS_MV;
      aics_pkg::SRC_NEG_IN: volt = NEG_MV;
      aics_pkg::SRC_CM_REF: volt = CM_MV;
      aics_pkg::SRC_TEMP: volt = TS_MV;
      aics_pkg::SRC_FIXED: volt = FIX_MV;
      aics_pkg::SRC_TAP_3: volt = VDD_MV * 3 / 16;
      aics_pkg::SRC_TAP_2: volt = VDD_MV * 2 / 16;
      default: volt = -1;
    endcase
  endfunction

  // Open switch leaves the input floating, so no level is defined
  always_comb
  begin
    if (volt(i_pos_src) < 0 || volt(i_neg_src) < 0)
      o_level = 'x;
    else if (!i_enable)
      o_level = '0;
    else
      o_level = 32'((volt(i_pos_src) - volt(i_neg_src)) * (1 << i_gain_shift));
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the amplifier input channel selector
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [9:0] SEL = aics_pkg::ADDR_INPUT_SELECT;
  localparam logic [9:0] MODE = aics_pkg::ADDR_AMP_MODE;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = '0;
  logic [31:0] rdata, got, level;
  logic wreq, amp_en, gain_ok, sel_ok;
  logic [2:0] pos, neg, shift;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [2:0] ep [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h6, 3'h0};
  logic [2:0] en [8] = '{3'h2, 3'h3, 3'h3, 3'h3, 3'h0, 3'h5, 3'h7, 3'h0};
  int dv [8] = '{200, 500, 300, 0, 0, 500, 100, 0};
  logic [2:0] gs [8] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0};

  aics_top aics_top_i (.i_clock(clock), .i_rstn(rstn), .i_address(address), .i_read(read),
    .i_write(write), .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
    .o_waitrequest(wreq), .o_amp_enable(amp_en), .o_pos_src(pos), .o_neg_src(neg),
    .o_gain_shift(shift), .o_gain_valid(gain_ok), .o_select_valid(sel_ok));
  aics_amp_model aics_amp_model_i (.i_enable(amp_en), .i_pos_src(pos), .i_neg_src(neg),
    .i_gain_shift(shift), .o_level(level));

  ////////////////////////////////////////
  initial forever #4 clock = ~clock;

  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      stop_test();
    end
  end

  task stop_test();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Request held until the edge that samples waitrequest low; no latency assumed
  task automatic bus(input logic rd, input logic [9:0] a, input logic [31:0] d,
    input logic [3:0] b);
    @(posedge clock);
    address <= a;
    read <= rd;
    write <= !rd;
    wdata <= d;
    be <= b;
    // Read just after the edge, before its updates, so these are the sampled values
    @(posedge clock);
    while (wreq !== 1'b0)
      @(posedge clock);
    got = rdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk(pos, 3'h1);
    chk(neg, 3'h2);
    chk(amp_en, 1'b0);
    chk(shift, 3'h0);
    bus(1'b1, SEL, '0, 4'hf);
    chk(got, 32'h0);
    // Gain and select settled before enable goes up
    bus(1'b0, MODE, 32'hf6, 4'hf);
    bus(1'b0, MODE, 32'hf7, 4'hf);
    @(negedge clock);
    chk(amp_en, 1'b1);
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b0, MODE, (c == 5) ? 32'hff : 32'hf7, 4'hf);
      bus(1'b0, SEL, 32'hf8 | 32'(c), 4'hf);
      bus(1'b1, SEL, '0, 4'hf);
      chk(got, 32'(c));
      chk(pos, ep[c]);
      chk(neg, en[c]);
      chk(sel_ok, c != 4 && c != 7);
      chk(amp_en, 1'b1);
      if (ep[c] != 3'h0)
        chk(level, 32'(dv[c] * ((c == 5) ? 1 : 128)));
    end
    // Wrong gain while the sensor is selected must be flagged
    bus(1'b0, SEL, 32'h5, 4'hf);
    bus(1'b0, MODE, 32'hf7, 4'hf);
    @(negedge clock);
    chk(gain_ok, 1'b0);
    chk(shift, 3'h0);
    bus(1'b0, SEL, 32'h0, 4'hf);
    for (int g = 0; g < 8; g++)
    begin
      bus(1'b0, MODE, 32'hf1 | 32'(g << 1), 4'hf);
      @(negedge clock);
      chk(gain_ok, g < 4 || g == 7);
      if (g < 4 || g == 7)
        chk(shift, gs[g]);
    end
    bus(1'b0, SEL, 32'h3, 4'he);
    bus(1'b0, 10'h000, 32'h3, 4'hf);
    bus(1'b1, 10'h000, '0, 4'hf);
    chk(got, 32'h0);
    bus(1'b1, SEL, '0, 4'hf);
    chk(got, 32'h0);
    bus(1'b0, MODE, 32'hfe, 4'hf);
    @(negedge clock);
    chk(amp_en, 1'b0);
    chk(level, 32'h0);
    // Second reset in mid-run
    bus(1'b0, SEL, 32'h6, 4'hf);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    bus(1'b1, SEL, '0, 4'hf);
    chk(got, 32'h0);
    bus(1'b1, MODE, '0, 4'hf);
    chk(got, 32'hbe);
    chk(pos, 3'h1);
    chk(neg, 3'h2);
    chk(amp_en, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
